/* beis_top.sv */
// Tester error insertion, receive detectors and latched status block
`timescale 1ns/1ns
module beis_top (
   input  wire logic                  i_ref_clk,     // 50 MHz clock
   input  wire logic                  i_rst_n,       // Async reset
   input  wire logic [beis_pkg::AW-1:0] i_addr,      // Register address
   input  wire logic [beis_pkg::DW-1:0] i_wdata,     // Write data
   input  wire logic                  i_wr,          // Write strobe
   input  wire logic                  i_rd,          // Read strobe
   output logic [beis_pkg::DW-1:0]    o_rdata,       // Read data, next cycle
   input  wire logic [beis_pkg::PS_W-1:0] i_pattern_sel, // Pattern kind
   input  wire logic                  i_tx_restart,  // Generator reload
   input  wire logic                  i_tx_bit_en,   // Generated bit valid
   input  wire logic                  i_tx_bit,      // Generated bit
   output logic                       o_tx_bit,      // Bit with errors
   output logic                       o_alt_upper_word, // Send high word
   input  wire logic                  i_rx_bit_en,   // Received bit valid
   input  wire logic                  i_rx_bit,      // Received bit
   input  wire logic                  i_rx_expected, // Expected bit
   input  wire logic                  i_count_load,  // Count load level
   input  wire logic                  i_tester_irq_master_en, // Interrupt master en
   output logic [beis_pkg::BIT_CNT_W-1:0] o_bit_count, // Loaded bit count
   output logic [beis_pkg::ERR_CNT_W-1:0] o_err_count, // Loaded err count
   output logic                       o_irq          // Interrupt, high
);
   import beis_pkg::*;

   function automatic logic reg_hit(input logic [AW-1:0] a,
                                    input logic [AW-1:0] off);
      reg_hit = (a == off);
   endfunction

   // Host registers
   logic [CTRL_W-1:0]    err_ctrl_r;
   logic [DW-1:0]        alt_word_repeat_r;
   logic [IRQ_SRC_W-1:0] irq_en_r;
   logic [LATCH_W-1:0]   latch_r;
   logic [LATCH_W-1:0]   latch_set;
   logic [LATCH_W-1:0]   latch_clr;
   logic [DW-1:0]        rdata_nxt;

   // Edge detection
   logic single_q_r;
   logic load_q_r;
   logic single_rise;
   logic load_rise;

   // Generator side
   logic [3:0]  word_bit_r;
   logic [DW-1:0] rep_r;
   logic        upper_r;
   logic        alt_mode;

   // Receive side
   beis_sync_t           sync_state_r;
   logic [5:0]           match_run_r;
   logic [WIN_N-1:0]     win_r;
   logic [6:0]           win_cnt_r;
   logic [6:0]           win_cnt_nxt;
   logic                 mis;
   logic                 sync_live;
   logic                 sync_q_r;
   logic [BIT_CNT_W-1:0] bit_cnt_r;
   logic [ERR_CNT_W-1:0] err_cnt_r;
   logic                 bit_sat;
   logic                 err_sat;
   logic                 bit_sat_q_r;
   logic                 err_sat_q_r;
   logic [5:0]           zero_run_r;
   logic [5:0]           one_run_r;
   logic                 all_zero;
   logic                 all_one;

   beis_ins_if ins_if ();

   assign single_rise = err_ctrl_r[B_SINGLE] & ~single_q_r;
   assign load_rise   = i_count_load & ~load_q_r;

   assign ins_if.bit_en     = i_tx_bit_en;
   assign ins_if.bit_in     = i_tx_bit;
   assign ins_if.rate_code  = err_ctrl_r[RATE_LSB +: RATE_W];
   assign ins_if.single_req = single_rise;
   assign o_tx_bit          = ins_if.bit_out;

   beis_err_insert u_ins (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .io_ins    (ins_if)
   );

   // Register writes
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         err_ctrl_r        <= '0;
         alt_word_repeat_r <= RST_BYTE;
         irq_en_r          <= '0;
      end else if (i_wr) begin
         if (reg_hit(i_addr, OFF_ERR_CTRL)) begin
            err_ctrl_r <= i_wdata[CTRL_W-1:0];
         end
         if (reg_hit(i_addr, OFF_ALT_CNT)) begin
            alt_word_repeat_r <= i_wdata;
         end
         if (reg_hit(i_addr, OFF_IRQ_EN)) begin
            irq_en_r <= i_wdata[IRQ_SRC_W-1:0];
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         single_q_r <= 1'b0;
         load_q_r   <= 1'b0;
      end else begin
         single_q_r <= err_ctrl_r[B_SINGLE];
         load_q_r   <= i_count_load;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = RST_BYTE;
      if (reg_hit(i_addr, OFF_ERR_CTRL)) begin
         rdata_nxt[CTRL_W-1:0] = err_ctrl_r;
      end else if (reg_hit(i_addr, OFF_ALT_CNT)) begin
         rdata_nxt = alt_word_repeat_r;
      end else if (reg_hit(i_addr, OFF_STAT_LIVE)) begin
         rdata_nxt[ST_SYNC] = sync_live;
         rdata_nxt[ST_ECO]  = err_sat;
         rdata_nxt[ST_BCO]  = bit_sat;
         rdata_nxt[ST_ZERO] = all_zero;
         rdata_nxt[ST_ONE]  = all_one;
      end else if (reg_hit(i_addr, OFF_STAT_LATCH)) begin
         rdata_nxt[LATCH_W-1:0] = latch_r;
      end else if (reg_hit(i_addr, OFF_IRQ_EN)) begin
         rdata_nxt[IRQ_SRC_W-1:0] = irq_en_r;
      end
   end

   // Data stands only in the cycle after the strobe
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= RST_BYTE;
      end else begin
         o_rdata <= i_rd ? rdata_nxt : RST_BYTE;
      end
   end

   // Alternating-word sequencing, idle outside that mode
   assign alt_mode = (i_pattern_sel == PS_ALT);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         word_bit_r <= '0;
         rep_r      <= '0;
         upper_r    <= 1'b0;
      end else if (i_tx_restart || !alt_mode) begin
         word_bit_r <= '0;
         rep_r      <= '0;
         upper_r    <= 1'b0;
      end else if (i_tx_bit_en) begin
         word_bit_r <= word_bit_r + 1'b1;
         if (word_bit_r == WORD_LAST) begin
            if (rep_r == alt_word_repeat_r) begin
               rep_r   <= '0;
               upper_r <= ~upper_r;
            end else begin
               rep_r <= rep_r + 1'b1;
            end
         end
      end
   end

   assign o_alt_upper_word = upper_r;

   // Lock hunting and loss window
   assign mis         = i_rx_bit ^ i_rx_expected;
   assign sync_live   = (sync_state_r == SYNC_LOCK);
   assign win_cnt_nxt = win_cnt_r + {6'h00, mis} - {6'h00, win_r[WIN_N-1]};

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_state_r <= SYNC_HUNT;
         match_run_r  <= '0;
         win_r        <= '0;
         win_cnt_r    <= '0;
      end else if (i_rx_bit_en) begin
         unique case (sync_state_r)
            SYNC_HUNT: begin
               win_r     <= '0;
               win_cnt_r <= '0;
               if (mis) begin
                  match_run_r <= '0;
               end else if (match_run_r == SYNC_MATCH_N - 6'h01) begin
                  sync_state_r <= SYNC_LOCK;
                  match_run_r  <= '0;
               end else begin
                  match_run_r <= match_run_r + 1'b1;
               end
            end
            SYNC_LOCK: begin
               win_r     <= {win_r[WIN_N-2:0], mis};
               win_cnt_r <= win_cnt_nxt;
               if (win_cnt_nxt >= LOSS_ERR_N) begin
                  sync_state_r <= SYNC_HUNT;
               end
            end
         endcase
      end
   end

   // Saturating counters, copied out and cleared by count load
   assign bit_sat = &bit_cnt_r;
   assign err_sat = &err_cnt_r;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_cnt_r   <= '0;
         err_cnt_r   <= '0;
         o_bit_count <= '0;
         o_err_count <= '0;
      end else if (load_rise) begin
         o_bit_count <= bit_cnt_r;
         o_err_count <= err_cnt_r;
         bit_cnt_r   <= '0;
         err_cnt_r   <= '0;
      end else if (i_rx_bit_en && sync_live) begin
         if (!bit_sat) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end
         if (mis && !err_sat) begin
            err_cnt_r <= err_cnt_r + 1'b1;
         end
      end
   end

   // Run detectors for all-zero and all-one streams
   assign all_zero = (zero_run_r == RUN_N);
   assign all_one  = (one_run_r == RUN_N);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         zero_run_r <= '0;
         one_run_r  <= '0;
      end else if (i_rx_bit_en) begin
         if (i_rx_bit) begin
            zero_run_r <= '0;
            one_run_r  <= all_one ? one_run_r : one_run_r + 1'b1;
         end else begin
            one_run_r  <= '0;
            zero_run_r <= all_zero ? zero_run_r : zero_run_r + 1'b1;
         end
      end
   end

   // Latched flags; a set in the clearing cycle wins
   always_comb begin
      latch_set          = '0;
      latch_set[LT_SYNC] = sync_live ^ sync_q_r;
      latch_set[LT_ECO]  = err_sat & ~err_sat_q_r;
      latch_set[LT_BCO]  = bit_sat & ~bit_sat_q_r;
      latch_set[LT_BED]  = i_rx_bit_en & sync_live & mis;
      latch_set[LT_ZERO] = all_zero;
      latch_set[LT_ONE]  = all_one;
      latch_clr = '0;
      if (i_wr && reg_hit(i_addr, OFF_STAT_LATCH)) begin
         latch_clr = i_wdata[LATCH_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_r     <= '0;
         sync_q_r    <= 1'b0;
         err_sat_q_r <= 1'b0;
         bit_sat_q_r <= 1'b0;
      end else begin
         latch_r     <= (latch_r & ~latch_clr) | latch_set;
         sync_q_r    <= sync_live;
         err_sat_q_r <= err_sat;
         bit_sat_q_r <= bit_sat;
      end
   end

   // Only the low four flags can reach the interrupt
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= i_tester_irq_master_en &
                  (|(latch_r[IRQ_SRC_W-1:0] & irq_en_r));
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_run_done;
      sync_state_r == SYNC_HUNT && i_rx_bit_en && !mis &&
      match_run_r == SYNC_MATCH_N - 6'h01;
   endsequence

   AST_SYNC_ACQ: assert property (s_run_done |=> sync_live)
      else $error("lock not taken after matching run");
   AST_SYNC_LOSS: assert property (
      sync_live && i_rx_bit_en && win_cnt_nxt >= LOSS_ERR_N |=> !sync_live)
      else $error("lock kept despite error burst");
   AST_LOCK_FLAG: assert property (
      sync_live != $past(sync_live) |=> latch_r[LT_SYNC])
      else $error("lock change not latched");
   AST_LOAD: assert property (
      load_rise |=> bit_cnt_r == '0 && o_bit_count == $past(bit_cnt_r))
      else $error("count load did not copy and clear");
   AST_IRQ_ON: assert property (
      i_tester_irq_master_en && |(latch_r[IRQ_SRC_W-1:0] & irq_en_r)
      |=> o_irq)
      else $error("interrupt missing");
   AST_IRQ_OFF: assert property (
      !i_tester_irq_master_en || !(|(latch_r[IRQ_SRC_W-1:0] & irq_en_r))
      |=> !o_irq)
      else $error("interrupt without enabled flag");
   AST_BED_UNLOCKED: assert property (
      !sync_live && !latch_r[LT_BED]
      |=> !latch_r[LT_BED])
      else $error("bit error flag set while unlocked");
   AST_ALT_TURN: assert property (
      alt_mode && !i_tx_restart && $changed(upper_r) && $past(alt_mode) &&
      !$past(i_tx_restart) |-> $past(word_bit_r) == WORD_LAST)
      else $error("word switch off a word boundary");
endmodule // beis_top

/* beis_pkg.sv */
// Constants, types and helpers shared by the tester error and status logic
package beis_pkg;

   localparam int unsigned AW          = 8;
   localparam int unsigned DW          = 8;

   // Register offsets
   localparam logic [AW-1:0] OFF_ERR_CTRL   = 8'h32;
   localparam logic [AW-1:0] OFF_ALT_CNT    = 8'h33;
   localparam logic [AW-1:0] OFF_STAT_LIVE  = 8'h38;
   localparam logic [AW-1:0] OFF_STAT_LATCH = 8'h39;
   localparam logic [AW-1:0] OFF_IRQ_EN     = 8'h3A;
   localparam logic [DW-1:0] RST_BYTE       = 8'h00;

   // error_insert_control fields
   localparam int unsigned B_SINGLE    = 0;
   localparam int unsigned RATE_LSB    = 1;
   localparam int unsigned RATE_W      = 3;
   localparam int unsigned CTRL_W      = 4;

   // pattern_status_live bit positions
   localparam int unsigned ST_SYNC     = 0;
   localparam int unsigned ST_ECO      = 1;
   localparam int unsigned ST_BCO      = 2;
   localparam int unsigned ST_ZERO     = 4;
   localparam int unsigned ST_ONE      = 5;

   // pattern_status_latched / irq enable bit positions
   localparam int unsigned LT_SYNC     = 0;
   localparam int unsigned LT_ECO      = 1;
   localparam int unsigned LT_BCO      = 2;
   localparam int unsigned LT_BED      = 3;
   localparam int unsigned LT_ZERO     = 4;
   localparam int unsigned LT_ONE      = 5;
   localparam int unsigned LATCH_W     = 6;
   localparam int unsigned IRQ_SRC_W   = 4;

   // Receive thresholds and widths
   localparam logic [5:0] SYNC_MATCH_N = 6'h20;
   localparam int unsigned WIN_N       = 64;
   localparam logic [6:0] LOSS_ERR_N   = 7'h06;
   localparam logic [5:0] RUN_N        = 6'h20;
   localparam int unsigned ERR_CNT_W   = 24;
   localparam int unsigned BIT_CNT_W   = 32;

   // Generator side
   localparam logic [3:0] WORD_LAST    = 4'hF;
   localparam int unsigned PS_W        = 3;
   localparam logic [PS_W-1:0] PS_ALT  = 3'h1;
   localparam int unsigned DEC_W       = 24;

   typedef enum logic {SYNC_HUNT, SYNC_LOCK} beis_sync_t;

   // Last count of the decade counter for each rate code
   function automatic logic [DEC_W-1:0] rate_limit(
      input logic [RATE_W-1:0] code);
      unique case (code)
         3'h1:    rate_limit = 24'h000009;
         3'h2:    rate_limit = 24'h000063;
         3'h3:    rate_limit = 24'h0003E7;
         3'h4:    rate_limit = 24'h00270F;
         3'h5:    rate_limit = 24'h01869F;
         3'h6:    rate_limit = 24'h0F423F;
         3'h7:    rate_limit = 24'h98967F;
         default: rate_limit = 24'h000000;
      endcase
   endfunction

endpackage

/* beis_ins_if.sv */
// Link between the control logic and the error inserter
`timescale 1ns/1ns
interface beis_ins_if;
   import beis_pkg::*;
   logic              bit_en;
   logic              bit_in;
   logic              bit_out;
   logic [RATE_W-1:0] rate_code;
   logic              single_req;
   modport ctrl (output bit_en, bit_in, rate_code, single_req,
                 input  bit_out);
   modport ins  (input  bit_en, bit_in, rate_code, single_req,
                 output bit_out);
endinterface

/* beis_err_insert.sv */
// Single and rate-based bit error inserter on the generated stream
`timescale 1ns/1ns
module beis_err_insert (
   input  wire logic i_ref_clk,   // System clock
   input  wire logic i_rst_n,     // Async reset, active low
   beis_ins_if.ins   io_ins       // Stream and insertion controls
);
   import beis_pkg::*;

   logic [DEC_W-1:0]  dec_r;
   logic [RATE_W-1:0] rate_q_r;
   logic              single_pend_r;
   logic              bit_out_r;
   logic              rate_hit;
   logic              rate_same;

   assign rate_same = (io_ins.rate_code == rate_q_r);
   assign rate_hit  = (io_ins.rate_code != '0) && rate_same &&
                      (dec_r == rate_limit(io_ins.rate_code));
   assign io_ins.bit_out = bit_out_r;

   // Decade counter of generated bits, restarted on a rate change
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dec_r    <= '0;
         rate_q_r <= '0;
      end else begin
         rate_q_r <= io_ins.rate_code;
         if (!rate_same) begin
            dec_r <= '0;
         end else if (io_ins.bit_en) begin
            dec_r <= rate_hit ? '0 : dec_r + 1'b1;
         end
      end
   end

   // A request landing with a bit is kept for the following bit
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         single_pend_r <= 1'b0;
      end else if (io_ins.single_req) begin
         single_pend_r <= 1'b1;
      end else if (io_ins.bit_en) begin
         single_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_out_r <= 1'b0;
      end else if (io_ins.bit_en) begin
         bit_out_r <= io_ins.bit_in ^ (rate_hit | single_pend_r);
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   AST_RATE_WRAP: assert property (
      io_ins.bit_en && rate_hit && !single_pend_r
      |=> bit_out_r != $past(io_ins.bit_in))
      else $error("rate wrap did not invert the bit");
   AST_NO_ERR: assert property (
      io_ins.bit_en && !rate_hit && !single_pend_r
      |=> bit_out_r == $past(io_ins.bit_in))
      else $error("bit inverted without cause");
   AST_SINGLE_ONCE: assert property (
      single_pend_r && io_ins.bit_en && !io_ins.single_req
      |=> !single_pend_r)
      else $error("single error applied more than once");
endmodule // beis_err_insert

/* beis_framer_model.sv */
// Framer datapath model: generated and received serial bit streams
`timescale 1ns/1ns
module beis_framer_model (
   input  wire logic i_ref_clk,   // System clock
   input  wire logic i_tx_seen,   // Generated bit after insertion
   output logic      o_tx_bit_en, // Generated bit valid
   output logic      o_tx_bit,    // Generated bit
   output logic      o_rx_bit_en, // Received bit valid
   output logic      o_rx_bit,    // Received bit
   output logic      o_rx_exp     // Expected bit
);
   logic        tx_en_d;
   logic        tx_bit_d;
   int unsigned flips;
   initial begin
      {o_tx_bit_en, o_tx_bit, o_rx_bit_en, o_rx_bit, o_rx_exp} = 5'h00;
      {tx_en_d, tx_bit_d} = 2'h0;
      flips = 0;
   end
   // Inserted errors show one cycle after each generated bit
   always @(posedge i_ref_clk) begin
      if (tx_en_d && (i_tx_seen !== tx_bit_d)) begin
         flips <= flips + 1;
      end
      tx_en_d  <= o_tx_bit_en;
      tx_bit_d <= o_tx_bit;
   end
   task automatic tx_bits(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge i_ref_clk);
         o_tx_bit_en <= 1'b1;
         o_tx_bit    <= k[0];
      end
      @(posedge i_ref_clk);
      o_tx_bit_en <= 1'b0;
      o_tx_bit    <= ~o_tx_bit;
   endtask
   // Idle data lines flip so a stale bit is never mistaken for data
   task automatic rx_bits(input int n, input logic b, e, alt);
      for (int k = 0; k < n; k++) begin
         @(posedge i_ref_clk);
         o_rx_bit_en <= 1'b1;
         o_rx_bit    <= b ^ (alt & k[0]);
         o_rx_exp    <= e ^ (alt & k[0]);
      end
      @(posedge i_ref_clk);
      o_rx_bit_en <= 1'b0;
      o_rx_bit    <= ~o_rx_bit;
      o_rx_exp    <= ~o_rx_exp;
   endtask
endmodule // beis_framer_model

/* bert_error_insert_and_status_bench.sv */
// Self-checking bench for the tester error insertion and status block
`timescale 1ns/1ns
module bert_error_insert_and_status_bench;
   import beis_pkg::*;
   logic        i_ref_clk, i_rst_n, i_wr, i_rd, i_tx_restart;
   logic        i_count_load, i_master_en, tx_en, tx_bit, tx_out;
   logic        alt_up, rx_en, rx_bit, rx_exp, o_irq;
   logic [7:0]  i_addr, i_wdata, o_rdata;
   logic [2:0]  i_pattern_sel;
   logic [31:0] o_bit_count;
   logic [23:0] o_err_count;
   int          miscompares, n_compared, cycles;
   beis_top beis_top_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_pattern_sel(i_pattern_sel),
      .i_tx_restart(i_tx_restart), .i_tx_bit_en(tx_en), .i_tx_bit(tx_bit),
      .o_tx_bit(tx_out), .o_alt_upper_word(alt_up), .i_rx_bit_en(rx_en),
      .i_rx_bit(rx_bit), .i_rx_expected(rx_exp),
      .i_count_load(i_count_load), .i_tester_irq_master_en(i_master_en),
      .o_bit_count(o_bit_count), .o_err_count(o_err_count), .o_irq(o_irq));
   beis_framer_model beis_framer_model_i (.i_ref_clk(i_ref_clk),
      .i_tx_seen(tx_out), .o_tx_bit_en(tx_en), .o_tx_bit(tx_bit),
      .o_rx_bit_en(rx_en), .o_rx_bit(rx_bit), .o_rx_exp(rx_exp));
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end
   task automatic final_report;
      $display("Compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Tests need a few thousand cycles at most
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] ex, got);
      n_compared++;
      if (got !== ex) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", nm, ex, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_ref_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_ref_clk);
      i_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, ex, input string nm);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_ref_clk);
      i_rd   <= 1'b0;
      @(negedge i_ref_clk);
      chk(nm, 32'(ex), 32'(o_rdata));
   endtask
   task automatic irq_step(input logic m, ex);
      @(posedge i_ref_clk);
      i_master_en <= m;
      repeat (2) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk("irq", 32'(ex), 32'(o_irq));
   endtask
   task automatic load_pulse;
      @(posedge i_ref_clk);
      i_count_load <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_count_load <= 1'b0;
      @(negedge i_ref_clk);
   endtask
   task automatic tx_run(input int n, input logic [31:0] ex);
      int unsigned base;
      base = beis_framer_model_i.flips;
      beis_framer_model_i.tx_bits(n);
      repeat (2) @(posedge i_ref_clk);
      chk("inserted errors", ex, beis_framer_model_i.flips - base);
   endtask
   initial begin
      {i_rst_n, i_wr, i_rd, i_tx_restart, i_count_load, i_master_en} = 6'h00;
      {i_addr, i_wdata, i_pattern_sel} = 19'h00000;
      repeat (6) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      rd(OFF_ALT_CNT, RST_BYTE, "repeat count reset");
      rd(OFF_IRQ_EN, RST_BYTE, "irq enable reset");
      rd(8'h50, 8'h00, "unmapped");
      wr(OFF_ALT_CNT, 8'hA5);
      rd(OFF_ALT_CNT, 8'hA5, "repeat count");
      wr(OFF_STAT_LIVE, 8'hFF);
      rd(OFF_STAT_LIVE, 8'h00, "live read only");
      $display("Registers test done");
      beis_framer_model_i.rx_bits(32, 1'b0, 1'b0, 1'b1);
      rd(OFF_STAT_LIVE, 8'h01, "lock");
      rd(OFF_STAT_LATCH, 8'h01, "lock change");
      wr(OFF_IRQ_EN, 8'h01);
      irq_step(1'b1, 1'b1);
      irq_step(1'b0, 1'b0);
      irq_step(1'b1, 1'b1);
      wr(OFF_STAT_LATCH, 8'h01);
      rd(OFF_STAT_LATCH, 8'h00, "lock change clear");
      irq_step(1'b1, 1'b0);
      beis_framer_model_i.rx_bits(6, 1'b1, 1'b0, 1'b1);
      rd(OFF_STAT_LIVE, 8'h00, "lock lost");
      rd(OFF_STAT_LATCH, 8'h09, "flags after loss");
      wr(OFF_IRQ_EN, 8'h08);
      wr(OFF_STAT_LATCH, 8'h01);
      irq_step(1'b1, 1'b1);
      wr(OFF_STAT_LATCH, 8'h3F);
      beis_framer_model_i.rx_bits(4, 1'b1, 1'b0, 1'b1);
      rd(OFF_STAT_LATCH, 8'h00, "no error unlocked");
      $display("Lock and interrupt test done");
      beis_framer_model_i.rx_bits(32, 1'b0, 1'b0, 1'b0);
      rd(OFF_STAT_LIVE, 8'h11, "all zero");
      wr(OFF_IRQ_EN, 8'h0E);
      wr(OFF_STAT_LATCH, 8'h01);
      rd(OFF_STAT_LATCH, 8'h10, "all zero flag");
      irq_step(1'b1, 1'b0);
      beis_framer_model_i.rx_bits(1, 1'b1, 1'b1, 1'b0);
      rd(OFF_STAT_LIVE, 8'h01, "all zero gone");
      beis_framer_model_i.rx_bits(32, 1'b1, 1'b1, 1'b0);
      rd(OFF_STAT_LIVE, 8'h21, "all one");
      beis_framer_model_i.rx_bits(1, 1'b0, 1'b0, 1'b0);
      rd(OFF_STAT_LIVE, 8'h01, "all one gone");
      load_pulse();
      beis_framer_model_i.rx_bits(10, 1'b0, 1'b0, 1'b1);
      load_pulse();
      chk("bit count", 32'd10, o_bit_count);
      chk("err count", 32'd0, 32'(o_err_count));
      $display("Receive status test done");
      wr(OFF_ERR_CTRL, 8'hF2);
      rd(OFF_ERR_CTRL, 8'h02, "error control");
      tx_run(30, 32'd3);
      tx_run(5, 32'd0);
      wr(OFF_ERR_CTRL, 8'h04);
      tx_run(99, 32'd0);
      tx_run(101, 32'd2);
      wr(OFF_ERR_CTRL, 8'h06);
      tx_run(1000, 32'd1);
      wr(OFF_ERR_CTRL, 8'h00);
      wr(OFF_ERR_CTRL, 8'h01);
      tx_run(8, 32'd1);
      tx_run(8, 32'd0);
      wr(OFF_ERR_CTRL, 8'h00);
      wr(OFF_ERR_CTRL, 8'h01);
      tx_run(8, 32'd1);
      $display("Error insertion test done");
      wr(OFF_ALT_CNT, 8'h01);
      @(posedge i_ref_clk);
      i_pattern_sel <= PS_ALT;
      i_tx_restart  <= 1'b1;
      @(posedge i_ref_clk);
      i_tx_restart  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         beis_framer_model_i.tx_bits(16);
         @(negedge i_ref_clk);
         chk("upper word", 32'(i == 1 || i == 2), 32'(alt_up));
      end
      @(posedge i_ref_clk);
      i_pattern_sel <= 3'h2;
      beis_framer_model_i.tx_bits(48);
      @(negedge i_ref_clk);
      chk("upper word idle", 32'd0, 32'(alt_up));
      $display("Alternating word test done");
      final_report();
   end
endmodule // bert_error_insert_and_status_bench
